//--- core/psim_core.v
// serial-bus status, readback, identification and mode register block
`timescale 1ns/1ps
`include "psim_regs.vh"

module psim_core #(
    parameter [6:0] DEV_ADDR = 7'h40,
    // maker, model and revision characters: arbitrary values
    parameter [7:0] MAKER_CHAR = 8'h41,
    parameter [7:0] MODEL_CHAR = 8'h42,
    parameter [15:0] HWFW_CHARS = 16'h4141,
    parameter MS_CYCLES = `PSIM_CLK_KHZ
) (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // serial bus pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    output reg alert_out,
    output reg alert_oe_n,
    // supply and sensor conditions
    input wire supply_off_cause,
    input wire supply_disabled,
    input wire ot_warning_in,
    input wire overtemp_fault_flag_in,
    input wire watchdog_reset_evt,
    input wire margin_fail_evt,
    input wire vout_above_pg_on,
    input wire vout_below_pg_off,
    input wire overcurrent_fault_flag_in,
    input wire oc_warning_in,
    // measurements
    input wire [15:0] vout_meas,
    input wire [15:0] iout_meas,
    input wire [15:0] temp_meas,
    input wire temp_sensor_faulty,
    input wire temp_sensor_disabled,
    // event log and housekeeping
    output reg log_snapshot_go,
    output reg log_erase_go,
    input wire log_done,
    input wire log_error,
    output reg store_defaults_go,
    output reg soft_reset_go
);

localparam [4:0] S_IDLE = 5'h01;
localparam [4:0] S_RX = 5'h02;
localparam [4:0] S_ACK = 5'h04;
localparam [4:0] S_TX = 5'h08;
localparam [4:0] S_MACK = 5'h10;

function [63:0] text_put;
    input [63:0] s;
    input [3:0] k;
    input [7:0] d;
    reg [6:0] sh;
    begin
        sh = {k - 4'h1, 3'b000};
        text_put = (s & ~(64'h00000000000000ff << sh)) | ({56'h0, d} << sh);
    end
endfunction

function [7:0] text_get;
    input [63:0] s;
    input [3:0] k;
    reg [63:0] t;
    begin
        t = s >> {k - 4'h1, 3'b000};
        text_get = (k == 4'h0) ? `PSIM_TEXT_LEN : t[7:0];
    end
endfunction

function [9:0] ms_next;
    input [9:0] cnt;
    input [9:0] period;
    begin
        ms_next = (cnt >= period - 10'd1) ? 10'd0 : cnt + 10'd1;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and bus conditions

reg scl_s1_q, scl_s2_q, scl_s3_q;
reg sda_s1_q, sda_s2_q, sda_s3_q;
wire scl_rise = scl_s2_q & ~scl_s3_q;
wire scl_fall = ~scl_s2_q & scl_s3_q;
wire bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
wire bus_stop = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

always @(posedge clk_sys) begin
    if (reset) begin
        {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'b111;
        {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'b111;
    end else begin
        {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
        {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
    end
end

////////////////////////////////////////////////////////////////////////////////
// register state

reg [7:0] vstat_q;
reg cml_q, other_q, pg_word_q, pg_armed_q, ara_served_q;
reg [7:0] mode_hi_q;
reg [15:0] vout_q, iout_q, temp_q;
reg [63:0] site_q, date_q, serial_q;
reg [7:0] cmd_q;
reg ara_q;
reg [3:0] rd_idx_q;
reg [7:0] rdata;

wire [7:0] sword_hi = {3'b000, |vstat_q, pg_word_q, 3'b000};
wire [7:0] sbyte = {6'b000000, cml_q, other_q};

always @* begin
    rdata = 8'h00;
    if (ara_q) begin
        rdata = {DEV_ADDR, 1'b0};
    end else begin
        case (cmd_q)
            `PSIM_CMD_STATUS_BYTE: rdata = sbyte;
            `PSIM_CMD_STATUS_WORD: rdata = rd_idx_q[0] ? sword_hi : sbyte;
            `PSIM_CMD_VENDOR_STATUS: rdata = vstat_q;
            `PSIM_CMD_VOUT: rdata = rd_idx_q[0] ? vout_q[15:8] : vout_q[7:0];
            `PSIM_CMD_IOUT: rdata = rd_idx_q[0] ? iout_q[15:8] : iout_q[7:0];
            `PSIM_CMD_TEMP: rdata = rd_idx_q[0] ? temp_q[15:8] : temp_q[7:0];
            `PSIM_CMD_PROTO_REV: rdata = `PSIM_PROTO_REV;
            `PSIM_CMD_MAKER: rdata = MAKER_CHAR;
            `PSIM_CMD_MODEL: rdata = MODEL_CHAR;
            `PSIM_CMD_HWFW_REV: rdata = rd_idx_q[0] ? HWFW_CHARS[15:8] : HWFW_CHARS[7:0];
            `PSIM_CMD_SITE: rdata = text_get(site_q, rd_idx_q);
            `PSIM_CMD_DATE: rdata = text_get(date_q, rd_idx_q);
            `PSIM_CMD_SERIAL: rdata = text_get(serial_q, rd_idx_q);
            `PSIM_CMD_MODE: rdata = rd_idx_q[0] ? mode_hi_q : 8'h00;
            default: rdata = 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// serial bus slave

reg [4:0] st_q;
reg [2:0] bit_q;
reg [7:0] sh_q, tx_q;
reg full_q, rd_q;
reg [3:0] idx_q;
reg wr_stb_q, clear_stb_q, ara_hit_q;
reg [7:0] wr_data_q;
reg [3:0] wr_idx_q;
wire alert_pend = |(vstat_q & `PSIM_VS_ALERT_MASK) | cml_q;
wire alert_act = mode_hi_q[`PSIM_MD_ALERT] & alert_pend & ~ara_served_q;

always @(posedge clk_sys) begin
    wr_stb_q <= 1'b0;
    clear_stb_q <= 1'b0;
    ara_hit_q <= 1'b0;
    store_defaults_go <= 1'b0;
    if (reset) begin
        st_q <= S_IDLE;
        bit_q <= 3'd0;
        sh_q <= 8'h00;
        tx_q <= 8'h00;
        full_q <= 1'b0;
        rd_q <= 1'b0;
        ara_q <= 1'b0;
        idx_q <= 4'h0;
        rd_idx_q <= 4'h0;
        cmd_q <= 8'h00;
        wr_data_q <= 8'h00;
        wr_idx_q <= 4'h0;
        sda_out <= 1'b0;
        sda_oe_n <= 1'b1;
    end else if (bus_start) begin
        st_q <= S_RX;
        bit_q <= 3'd0;
        full_q <= 1'b0;
        idx_q <= 4'h0;
        ara_q <= 1'b0;
        sda_oe_n <= 1'b1;
    end else if (bus_stop) begin
        st_q <= S_IDLE;
        sda_oe_n <= 1'b1;
    end else begin
        case (st_q)
            S_RX: begin
                if (scl_rise) begin
                    sh_q <= {sh_q[6:0], sda_s2_q};
                    bit_q <= bit_q + 3'd1;
                    full_q <= (bit_q == 3'd7);
                end else if (scl_fall && full_q) begin
                    full_q <= 1'b0;
                    if (idx_q != 4'hf)
                        idx_q <= idx_q + 4'h1;
                    if (idx_q == 4'h0) begin
                        rd_q <= sh_q[0];
                        if (sh_q[7:1] == DEV_ADDR) begin
                            sda_oe_n <= 1'b0;
                            st_q <= S_ACK;
                        end else if (sh_q[7:1] == `PSIM_ARA_ADDR && sh_q[0] && alert_act) begin
                            ara_q <= 1'b1;
                            ara_hit_q <= 1'b1;
                            sda_oe_n <= 1'b0;
                            st_q <= S_ACK;
                        end else begin
                            st_q <= S_IDLE;
                        end
                    end else begin
                        sda_oe_n <= 1'b0;
                        st_q <= S_ACK;
                        if (idx_q == 4'h1) begin
                            cmd_q <= sh_q;
                            clear_stb_q <= (sh_q == `PSIM_CMD_CLEAR_FAULTS);
                            store_defaults_go <= (sh_q == `PSIM_CMD_STORE_ALL);
                        end else begin
                            wr_stb_q <= 1'b1;
                            wr_data_q <= sh_q;
                            wr_idx_q <= idx_q - 4'h2;
                        end
                    end
                end
            end
            S_ACK: begin
                if (scl_fall) begin
                    bit_q <= 3'd0;
                    if (rd_q) begin
                        tx_q <= rdata;
                        rd_idx_q <= 4'h1;
                        sda_oe_n <= rdata[7];
                        st_q <= S_TX;
                    end else begin
                        rd_idx_q <= 4'h0;
                        sda_oe_n <= 1'b1;
                        st_q <= S_RX;
                    end
                end
            end
            S_TX: begin
                if (scl_fall) begin
                    bit_q <= bit_q + 3'd1;
                    if (bit_q == 3'd7) begin
                        sda_oe_n <= 1'b1;
                        st_q <= S_MACK;
                    end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_n <= tx_q[6];
                    end
                end
            end
            S_MACK: begin
                if (scl_rise) begin
                    full_q <= ~sda_s2_q;
                end else if (scl_fall) begin
                    full_q <= 1'b0;
                    if (full_q) begin
                        tx_q <= rdata;
                        if (rd_idx_q != 4'hf)
                            rd_idx_q <= rd_idx_q + 4'h1;
                        sda_oe_n <= rdata[7];
                        st_q <= S_TX;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
            end
            S_IDLE: begin
                sda_oe_n <= 1'b1;
            end
            default: begin
                st_q <= S_IDLE;
                sda_oe_n <= 1'b1;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// sticky status and alert line

wire pg_lost_evt = pg_armed_q & vout_below_pg_off;
wire [7:0] vs_set;
assign vs_set[`PSIM_VS_OFF] = supply_off_cause & ~supply_disabled;
assign vs_set[`PSIM_VS_OVERTEMP_WARNING_FLAG] = ot_warning_in;
assign vs_set[`PSIM_VS_OVERTEMP_FAULT_FLAG] = overtemp_fault_flag_in;
assign vs_set[`PSIM_VS_WDOG] = watchdog_reset_evt;
assign vs_set[`PSIM_VS_MARGIN] = margin_fail_evt;
assign vs_set[`PSIM_VS_PG_LOST] = pg_lost_evt;
assign vs_set[`PSIM_VS_OVERCURRENT_FAULT_FLAG] = overcurrent_fault_flag_in;
assign vs_set[`PSIM_VS_OVERCURRENT_WARNING_FLAG] = oc_warning_in;
wire log_busy = mode_hi_q[`PSIM_MD_SNAP] | mode_hi_q[`PSIM_MD_ERASE];
wire cml_set = log_busy & log_done & log_error;
wire new_alert = |(vs_set & ~vstat_q & `PSIM_VS_ALERT_MASK) | (cml_set & ~cml_q);

always @(posedge clk_sys) begin
    if (reset) begin
        vstat_q <= 8'h00;
        cml_q <= 1'b0;
        other_q <= 1'b0;
        pg_word_q <= 1'b0;
        pg_armed_q <= 1'b0;
        ara_served_q <= 1'b0;
        alert_out <= 1'b0;
        alert_oe_n <= 1'b1;
    end else begin
        // set wins over a clear in the same cycle
        vstat_q <= (vstat_q & {8{~clear_stb_q}}) | vs_set;
        cml_q <= (cml_q & ~clear_stb_q) | cml_set;
        other_q <= (other_q & ~clear_stb_q) | pg_lost_evt;
        pg_word_q <= (pg_word_q & ~clear_stb_q) | pg_lost_evt;
        if (vout_above_pg_on)
            pg_armed_q <= 1'b1;
        else if (vout_below_pg_off)
            pg_armed_q <= 1'b0;
        if (new_alert || clear_stb_q)
            ara_served_q <= 1'b0;
        else if (ara_hit_q)
            ara_served_q <= 1'b1;
        alert_oe_n <= ~alert_act;
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode register, event log requests and soft reset

reg [1:0] sr_stage_q;
reg [9:0] sr_ms_q;
wire mode_wr = wr_stb_q & (cmd_q == `PSIM_CMD_MODE) & (wr_idx_q == 4'h1);
wire sr_bit = wr_data_q[`PSIM_MD_SOFT_RST];
wire ms_tick;

always @(posedge clk_sys) begin
    log_snapshot_go <= 1'b0;
    log_erase_go <= 1'b0;
    soft_reset_go <= 1'b0;
    if (reset) begin
        mode_hi_q <= `PSIM_MODE_HI_RST;
        sr_stage_q <= 2'd0;
        sr_ms_q <= 10'd0;
    end else begin
        if (log_busy && log_done) begin
            mode_hi_q[`PSIM_MD_SNAP] <= 1'b0;
            mode_hi_q[`PSIM_MD_ERASE] <= 1'b0;
        end
        if (mode_wr) begin
            mode_hi_q[`PSIM_MD_ALERT] <= wr_data_q[`PSIM_MD_ALERT];
            mode_hi_q[`PSIM_MD_SOFT_RST] <= sr_bit;
            if (wr_data_q[`PSIM_MD_SNAP] && !log_busy) begin
                mode_hi_q[`PSIM_MD_SNAP] <= 1'b1;
                log_snapshot_go <= 1'b1;
            end else if (wr_data_q[`PSIM_MD_ERASE] && !log_busy) begin
                mode_hi_q[`PSIM_MD_ERASE] <= 1'b1;
                log_erase_go <= 1'b1;
            end
        end
        // set, clear, set again inside the window
        if (sr_stage_q != 2'd0 && ms_tick)
            sr_ms_q <= sr_ms_q + 10'd1;
        if (sr_stage_q != 2'd0 && sr_ms_q >= `PSIM_SOFT_RST_WIN_MS) begin
            sr_stage_q <= 2'd0;
        end else if (mode_wr) begin
            case (sr_stage_q)
                2'd0: begin
                    if (sr_bit) begin
                        sr_stage_q <= 2'd1;
                        sr_ms_q <= 10'd0;
                    end
                end
                2'd1: begin
                    if (!sr_bit)
                        sr_stage_q <= 2'd2;
                end
                2'd2: begin
                    if (sr_bit) begin
                        soft_reset_go <= 1'b1;
                        sr_stage_q <= 2'd0;
                    end
                end
                default: sr_stage_q <= 2'd0;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// measurement refresh and text strings

reg [31:0] ms_cnt_q;
reg ms_tick_q;
reg [9:0] v_ms_q, i_ms_q, t_ms_q;
assign ms_tick = ms_tick_q;

always @(posedge clk_sys) begin
    if (reset) begin
        ms_cnt_q <= 32'd0;
        ms_tick_q <= 1'b0;
        v_ms_q <= 10'd0;
        i_ms_q <= 10'd0;
        t_ms_q <= 10'd0;
        vout_q <= 16'h0000;
        iout_q <= 16'h0000;
        temp_q <= `PSIM_TEMP_OFF;
    end else begin
        ms_tick_q <= (ms_cnt_q == MS_CYCLES - 1);
        ms_cnt_q <= (ms_cnt_q == MS_CYCLES - 1) ? 32'd0 : ms_cnt_q + 32'd1;
        if (ms_tick_q) begin
            v_ms_q <= ms_next(v_ms_q, `PSIM_VOUT_PERIOD_MS);
            i_ms_q <= ms_next(i_ms_q, `PSIM_IOUT_PERIOD_MS);
            t_ms_q <= ms_next(t_ms_q, `PSIM_TEMP_PERIOD_MS);
            if (v_ms_q == 10'd0)
                vout_q <= vout_meas;
            if (i_ms_q == 10'd0)
                iout_q <= iout_meas;
            if (t_ms_q == 10'd0) begin
                if (temp_sensor_faulty)
                    temp_q <= `PSIM_TEMP_FAULTY;
                else if (temp_sensor_disabled)
                    temp_q <= `PSIM_TEMP_OFF;
                else
                    temp_q <= temp_meas;
            end
        end
    end
end

wire text_wr = wr_stb_q & (wr_idx_q != 4'h0) & (wr_idx_q <= `PSIM_TEXT_LEN);

always @(posedge clk_sys) begin
    if (reset) begin
        site_q <= `PSIM_TEXT_RST;
        date_q <= `PSIM_TEXT_RST;
        serial_q <= `PSIM_TEXT_RST;
    end else if (text_wr) begin
        if (cmd_q == `PSIM_CMD_SITE)
            site_q <= text_put(site_q, wr_idx_q, wr_data_q);
        if (cmd_q == `PSIM_CMD_DATE)
            date_q <= text_put(date_q, wr_idx_q, wr_data_q);
        if (cmd_q == `PSIM_CMD_SERIAL)
            serial_q <= text_put(serial_q, wr_idx_q, wr_data_q);
    end
end

endmodule

//--- core/psim_regs.vh
// command codes, field positions, reset values and timing of the status/ident block
`ifndef PSIM_REGS_VH
`define PSIM_REGS_VH

// command codes
`define PSIM_CMD_CLEAR_FAULTS 8'h03
`define PSIM_CMD_STORE_ALL 8'h11
`define PSIM_CMD_STATUS_BYTE 8'h78
`define PSIM_CMD_STATUS_WORD 8'h79
`define PSIM_CMD_VENDOR_STATUS 8'h80
`define PSIM_CMD_VOUT 8'h8b
`define PSIM_CMD_IOUT 8'h8c
`define PSIM_CMD_TEMP 8'h8d
`define PSIM_CMD_PROTO_REV 8'h98
`define PSIM_CMD_MAKER 8'h99
`define PSIM_CMD_MODEL 8'h9a
`define PSIM_CMD_HWFW_REV 8'h9b
`define PSIM_CMD_SITE 8'h9c
`define PSIM_CMD_DATE 8'h9d
`define PSIM_CMD_SERIAL 8'h9e
`define PSIM_CMD_MODE 8'hd1

// vendor status bits
`define PSIM_VS_OFF 7
`define PSIM_VS_OVERTEMP_WARNING_FLAG 6
`define PSIM_VS_OVERTEMP_FAULT_FLAG 5
`define PSIM_VS_WDOG 4
`define PSIM_VS_MARGIN 3
`define PSIM_VS_PG_LOST 2
`define PSIM_VS_OVERCURRENT_FAULT_FLAG 1
`define PSIM_VS_OVERCURRENT_WARNING_FLAG 0
`define PSIM_VS_ALERT_MASK 8'h7b

// status byte / status word bits (word high byte positions)
`define PSIM_SB_CML 1
`define PSIM_SB_OTHER 0
`define PSIM_SW_HI_MFR 4
`define PSIM_SW_HI_PG 3

// mode register high byte bits (register bits 15, 14, 13, 11)
`define PSIM_MD_SNAP 7
`define PSIM_MD_ERASE 6
`define PSIM_MD_ALERT 5
`define PSIM_MD_SOFT_RST 3
`define PSIM_MODE_HI_RST 8'h00

// constant values
`define PSIM_PROTO_REV 8'h11
`define PSIM_TEXT_RST 64'h3031303130313031
`define PSIM_TEXT_LEN 8'h08
`define PSIM_TEMP_FAULTY 16'h7fff
`define PSIM_TEMP_OFF 16'h0000
`define PSIM_ARA_ADDR 7'h0c

// timing
`define PSIM_CLK_KHZ 250000
`define PSIM_VOUT_PERIOD_MS 10'd5
`define PSIM_IOUT_PERIOD_MS 10'd200
`define PSIM_TEMP_PERIOD_MS 10'd1000
`define PSIM_SOFT_RST_WIN_MS 8

`endif

//--- dv/psim_core_assertions.sv
// concurrent checks on the pins of the status, readback, identification and mode block
`timescale 1ns/1ps
module psim_core_assertions (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // bus pins
    input wire scl_in,
    input wire sda_oe_n,
    input wire alert_oe_n,
    // alert-class conditions
    input wire ot_warning_in,
    input wire overtemp_fault_flag_in,
    input wire watchdog_reset_evt,
    input wire margin_fail_evt,
    input wire overcurrent_fault_flag_in,
    input wire oc_warning_in,
    // log and housekeeping
    input wire log_snapshot_go,
    input wire log_erase_go,
    input wire log_done,
    input wire log_error,
    input wire store_defaults_go,
    input wire soft_reset_go
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // helper state: an alert-class cause was seen, a log action is open
    logic cause_q;
    logic busy_q;
    always @(posedge clk_sys) begin
        if (reset) begin
            cause_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            cause_q <= cause_q | ot_warning_in | overtemp_fault_flag_in | watchdog_reset_evt | margin_fail_evt
                | overcurrent_fault_flag_in | oc_warning_in | (log_done & log_error);
            busy_q <= (log_snapshot_go | log_erase_go) | (busy_q & ~log_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_reset_idle: assert property ($fell(reset) |-> sda_oe_n && alert_oe_n && !log_snapshot_go
        && !log_erase_go && !soft_reset_go && !store_defaults_go)
        else $error("outputs not idle after reset");
    chk_quiet_no_alert: assert property (!cause_q |-> alert_oe_n)
        else $error("alert without an alert-class cause");
    chk_snap_pulse: assert property (log_snapshot_go |=> !log_snapshot_go)
        else $error("snapshot start longer than one cycle");
    chk_snap_wins: assert property (log_snapshot_go |-> !log_erase_go)
        else $error("snapshot and erase started together");
    chk_log_busy: assert property (busy_q |-> !(log_snapshot_go || log_erase_go))
        else $error("log action restarted before done");
    chk_store_pulse: assert property (store_defaults_go |=> !store_defaults_go)
        else $error("store start longer than one cycle");
    chk_srst_spacing: assert property (soft_reset_go |=> !soft_reset_go [*8])
        else $error("soft reset pulses too close");
    chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data pin changed with bus clock high");

    cover property (log_snapshot_go);
    cover property (soft_reset_go);
    cover property ($fell(alert_oe_n));
    cover property (store_defaults_go);
endmodule

//--- dv/psim_core_tb_top.sv
// testbench for the status, readback, identification and mode block
`timescale 1ns/1ps
`include "psim_regs.vh"
module psim_core_tb_top;
    localparam logic [6:0] DEV = 7'h40;
    localparam logic [6:0] DEV2 = 7'h41;
    // identification characters: arbitrary values
    localparam logic [7:0] MK = 8'h5a;
    localparam logic [7:0] MD = 8'h6b;
    localparam logic [15:0] HF = 16'h3132;
    logic clk_sys, reset, supply_disabled, vout_above_pg_on, log_done, log_error, ok;
    logic temp_sensor_faulty, temp_sensor_disabled;
    logic [7:0] cond;
    logic [15:0] vout_meas, iout_meas, temp_meas;
    logic [71:0] rv;
    int err_count, cmp_count, snap_n, erase_n, store_n, srst_n;
    wire scl_in, sda_o, sda_out, sda_oe_n, sda_oe2_n, alert_out, alert_oe_n, srst2;
    wire log_snapshot_go, log_erase_go, store_defaults_go, soft_reset_go;
    wire sda_in = sda_o & (sda_oe_n | sda_out) & sda_oe2_n;
    wire supply_off_cause = cond[7];
    wire ot_warning_in = cond[6];
    wire overtemp_fault_flag_in = cond[5];
    wire watchdog_reset_evt = cond[4];
    wire margin_fail_evt = cond[3];
    wire vout_below_pg_off = cond[2];
    wire overcurrent_fault_flag_in = cond[1];
    wire oc_warning_in = cond[0];

    psim_core #(.DEV_ADDR(DEV), .MAKER_CHAR(MK), .MODEL_CHAR(MD), .HWFW_CHARS(HF), .MS_CYCLES(10)) dut (.*);
    // slow unit: three writes fit in its soft-reset window
    psim_core #(.DEV_ADDR(DEV2), .MS_CYCLES(500)) dut2 (.sda_out(), .sda_oe_n(sda_oe2_n), .alert_out(),
        .alert_oe_n(), .log_snapshot_go(), .log_erase_go(), .store_defaults_go(), .soft_reset_go(srst2), .*);
    psim_host host (.scl(scl_in), .sda_o(sda_o), .sda_line(sda_in));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        snap_n += log_snapshot_go;
        erase_n += log_erase_go;
        store_n += store_defaults_go;
        srst_n += srst2;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic acc(input logic [6:0] a, input logic r, input logic [7:0] c, input int n, input logic [71:0] wd);
        rv = r ? 72'h0 : wd;
        host.xfer(a, r, c, n, rv, ok);
        @(negedge clk_sys);
    endtask
    task automatic rdc(input logic [7:0] c, input int n, input logic [71:0] exp);
        acc(DEV, 1'b1, c, n, 72'h0);
        chk("ack", ok, 1'b1);
        chk($sformatf("cmd %h", c), rv, exp);
    endtask
    task automatic done_pulse(input logic e);
        @(negedge clk_sys);
        log_done = 1'b1;
        log_error = e;
        @(negedge clk_sys);
        log_done = 1'b0;
        log_error = 1'b0;
        cyc(4);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {cond, supply_disabled, vout_above_pg_on, log_done, log_error, temp_sensor_disabled} = '0;
        {vout_meas, iout_meas, temp_meas} = {16'h1234, 16'h0abc, 16'h0155};
        temp_sensor_faulty = 1'b1;
        reset = 1'b1;
        cyc(4);
        reset = 1'b0;
        cyc(8);
        rdc(`PSIM_CMD_TEMP, 2, 72'h7fff);
        rdc(`PSIM_CMD_VOUT, 2, 72'h1234);
        rdc(`PSIM_CMD_IOUT, 2, 72'h0abc);
        cyc(1);
        {temp_sensor_faulty, temp_sensor_disabled} = 2'b01;
        vout_meas = 16'h4321;
        iout_meas = 16'h0def;
        cyc(60);
        rdc(`PSIM_CMD_VOUT, 2, 72'h4321);
        rdc(`PSIM_CMD_PROTO_REV, 1, 72'h11);
        acc(DEV, 1'b0, `PSIM_CMD_PROTO_REV, 1, 72'h55);
        rdc(`PSIM_CMD_PROTO_REV, 1, 72'h11);
        rdc(`PSIM_CMD_MAKER, 1, MK);
        rdc(`PSIM_CMD_MODEL, 1, MD);
        rdc(`PSIM_CMD_HWFW_REV, 2, HF);
        rdc(`PSIM_CMD_SITE, 9, {`PSIM_TEXT_RST, 8'h08});
        acc(DEV, 1'b0, `PSIM_CMD_DATE, 9, {64'h3837363534333231, 8'h08});
        rdc(`PSIM_CMD_DATE, 9, {64'h3837363534333231, 8'h08});
        acc(DEV, 1'b0, `PSIM_CMD_STORE_ALL, 0, 72'h0);
        chk("store", store_n, 1);
        rdc(`PSIM_CMD_TEMP, 2, 72'h0000);
        temp_sensor_disabled = 1'b0;
        acc(DEV, 1'b0, `PSIM_CMD_MODE, 2, 72'h2000);
        for (int i = 7; i >= 0; i--) begin
            vout_above_pg_on = (i == 2);
            cyc(4);
            vout_above_pg_on = 1'b0;
            cond[i] = 1'b1;
            cyc(4);
            cond = '0;
            cyc(4);
            chk("alert", alert_oe_n, i == 7 || i == 2);
            rdc(`PSIM_CMD_VENDOR_STATUS, 1, 72'h1 << i);
            if (i == 2) rdc(`PSIM_CMD_STATUS_WORD, 2, 72'h1801);
            if (i == 6) begin
                acc(`PSIM_ARA_ADDR, 1'b1, 8'h00, 1, 72'h0);
                chk("ara", rv, {DEV, 1'b0});
                cyc(8);
                chk("alert", alert_oe_n, 1'b1);
            end
            acc(DEV, 1'b0, `PSIM_CMD_CLEAR_FAULTS, 0, 72'h0);
        end
        rdc(`PSIM_CMD_VENDOR_STATUS, 1, 72'h0);
        rdc(`PSIM_CMD_IOUT, 2, 72'h0def);
        acc(DEV, 1'b0, `PSIM_CMD_MODE, 2, 72'h0);
        cyc(2);
        {supply_disabled, cond[7], cond[1]} = 3'b111;
        cyc(4);
        {supply_disabled, cond} = '0;
        cyc(4);
        chk("alert", {alert_out, alert_oe_n}, 2'b01);
        rdc(`PSIM_CMD_VENDOR_STATUS, 1, 72'h02);
        acc(`PSIM_ARA_ADDR, 1'b1, 8'h00, 1, 72'h0);
        chk("ara ack", ok, 1'b0);
        acc(DEV, 1'b0, `PSIM_CMD_CLEAR_FAULTS, 0, 72'h0);
        rdc(`PSIM_CMD_TEMP, 2, 72'h0155);
        acc(DEV, 1'b0, `PSIM_CMD_MODE, 2, 72'h8000);
        chk("snap", snap_n, 1);
        rdc(`PSIM_CMD_MODE, 2, 72'h8000);
        done_pulse(1'b1);
        rdc(`PSIM_CMD_MODE, 2, 72'h0);
        rdc(`PSIM_CMD_STATUS_BYTE, 1, 72'h02);
        rdc(`PSIM_CMD_STATUS_WORD, 2, 72'h0002);
        acc(DEV, 1'b0, `PSIM_CMD_MODE, 2, 72'hc000);
        chk("snap", snap_n + 8 * erase_n, 2);
        done_pulse(1'b0);
        acc(DEV, 1'b0, `PSIM_CMD_MODE, 2, 72'h4000);
        chk("erase", erase_n, 1);
        done_pulse(1'b0);
        rdc(`PSIM_CMD_MODE, 2, 72'h0);
        // host side of the soft reset: set, clear, set again inside the window
        for (int i = 0; i < 3; i++) acc(DEV2, 1'b0, `PSIM_CMD_MODE, 2, {(i == 1) ? 8'h00 : 8'h08, 8'h00});
        chk("soft reset", srst_n, 1);
        acc(DEV2, 1'b0, `PSIM_CMD_MODE, 2, 72'h0);
        acc(DEV2, 1'b0, `PSIM_CMD_MODE, 2, 72'h0800);
        cyc(4500);
        acc(DEV2, 1'b0, `PSIM_CMD_MODE, 2, 72'h0);
        acc(DEV2, 1'b0, `PSIM_CMD_MODE, 2, 72'h0800);
        chk("soft reset", srst_n, 1);
        test_done();
    end
    initial begin
        #380000;
        err_count++;
        test_done();
    end
endmodule

bind psim_core psim_core_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in),
    .sda_oe_n(sda_oe_n), .alert_oe_n(alert_oe_n), .ot_warning_in(ot_warning_in), .overtemp_fault_flag_in(overtemp_fault_flag_in),
    .watchdog_reset_evt(watchdog_reset_evt), .margin_fail_evt(margin_fail_evt), .overcurrent_fault_flag_in(overcurrent_fault_flag_in),
    .oc_warning_in(oc_warning_in), .log_snapshot_go(log_snapshot_go), .log_erase_go(log_erase_go),
    .log_done(log_done), .log_error(log_error), .store_defaults_go(store_defaults_go),
    .soft_reset_go(soft_reset_go));

//--- dv/psim_host.sv
// bus host model: drives the clock and open-drain data of the serial bus
`timescale 1ns/1ps
`include "psim_regs.vh"
module psim_host (
    // bus pins
    output logic scl,
    output logic sda_o,
    input wire sda_line
);
    localparam realtime Q = 31.25;
    logic ack;
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    task automatic bitx(input logic b, output logic r);
        sda_o = b;
        #Q scl = 1'b1;
        #Q r = sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic start();
        sda_o = 1'b1;
        #Q scl = 1'b1;
        #Q sda_o = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic put(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(v[i], r);
        bitx(1'b1, r);
        ack = ack & ~r;
    endtask
    // n bytes low first; the alert response address has no command phase
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] c, input int n,
                        inout logic [71:0] d, output logic ok);
        logic r;
        ack = 1'b1;
        start();
        if (!(rd && a == `PSIM_ARA_ADDR)) begin
            put({a, 1'b0});
            put(c);
        end
        if (rd) begin
            if (a != `PSIM_ARA_ADDR) start();
            put({a, 1'b1});
        end
        for (int i = 0; i < n; i++) begin
            if (rd) begin
                for (int j = 7; j >= 0; j--) bitx(1'b1, d[8*i+j]);
                bitx(i == n - 1, r);
            end else begin
                put(d[8*i +: 8]);
            end
        end
        sda_o = 1'b0;
        #Q scl = 1'b1;
        #Q sda_o = 1'b1;
        #Q;
        ok = ack;
    endtask
endmodule
